// >>> logic/readout_pkg.sv
// Shared constants for the trigger readout and luminosity logic
// What this block does
// RULE1: One 8-bit serial command per crossing
// RULE2: Partner drives command data and link clock
// RULE3: Link clock divided by eight gives reference
// RULE4: 12-bit counter advances once per crossing
// RULE5: Trigger intake and readout run concurrently
// RULE6: Accept raises trigger pulse and tag immediately
// RULE7: Pixels copy tagged data into secondary buffer
// RULE8: Five-bit tag replaces crossing identifier in matrix
// RULE9: Crossing identifier and tag stored in table
// RULE10: New table entry makes column-ends fetch data
// RULE11: Fetched hits framed, serialised, sent on link
// RULE12: Hit link rate selectable among three rates
// RULE13: Narrow window one step, wide window programmable
// RULE14: Windows generated once per column, then distributed
// RULE15: Channel flags hits in narrow, wide window
// RULE16: Column-end counts flagged channels per window
// RULE17: Column counts summed into two chip totals
// RULE18: Difference of wide and narrow totals computed
// RULE19: Seven plus five truncated bits form word; the code saturates both fields, at 7F and 1F, instead of truncating
// RULE20: Word coded six-to-eight into 16-bit frame
// RULE21: Enable bit gates luminosity measurement and sending
// RULE22: Four 8-bit configuration registers per channel
// RULE23: Configuration readable, corruption flagged to serialiser
// RULE24: Four-bit window counter synchronous with crossings
package readout_pkg;
  // ==========================================================
  // Matrix geometry
  localparam int unsigned COLS        = 15;
  localparam int unsigned ROWS        = 15;
  localparam int unsigned CHANNELS    = COLS * ROWS;
  localparam int unsigned CFG_PER_CH  = 4;
  localparam int unsigned CFG_WORDS   = CHANNELS * CFG_PER_CH;
  localparam int unsigned CFG_AW      = 10;
  localparam logic [CFG_AW-1:0] CFG_LAST = 10'h383;
  localparam int unsigned CFG_EN_BIT  = 0;
  // ==========================================================
  // Fast command and crossing
  localparam int unsigned CMD_W       = 8;
  localparam int unsigned XING_W      = 12;
  localparam int unsigned TAG_W       = 5;
  localparam int unsigned DIVIDE      = 8;
  localparam logic [7:0] CMD_ACCEPT   = 8'hE1;
  localparam logic [7:0] CMD_XING_CLR = 8'h96;
  // ==========================================================
  // Hit readout framing
  localparam int unsigned HIT_W       = 17;
  localparam int unsigned WORD_W      = 24;
  localparam logic [1:0] MARK_HEAD    = 2'h2;
  localparam logic [1:0] MARK_HIT     = 2'h1;
  localparam logic [1:0] RATE_320     = 2'h0;
  localparam logic [1:0] RATE_640     = 2'h1;
  localparam logic [1:0] RATE_1280    = 2'h2;
  localparam int unsigned TABLE_DEPTH = 8;
  // ==========================================================
  // Luminosity
  localparam int unsigned PHASE_W     = 4;
  localparam logic [3:0] NARROW_FIRST = 4'h7;
  localparam int unsigned SUM_W       = 8;
  localparam int unsigned NARROW_OUT  = 7;
  localparam int unsigned DIFF_OUT    = 5;
  localparam int unsigned LUMI_W      = 12;
  localparam int unsigned FRAME_W     = 16;
  localparam int unsigned LUMI_STEP   = FRAME_W / DIVIDE;
endpackage : readout_pkg

// >>> logic/sync_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             core_clk,  // Clock
  input  wire logic             rst,       // Async reset
  input  wire logic [WIDTH-1:0] inData,    // Write word
  input  wire logic             inValid,   // Write request
  output logic                  inReady,   // Not full
  output logic      [WIDTH-1:0] outData,   // Head word
  output logic                  outValid,  // Not empty
  input  wire logic             outReady   // Pop request
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic             push;
  logic             pop;

  assign inReady  = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
  assign outValid = wrPtr != rdPtr;
  assign outData  = mem[rdPtr[AW-1:0]];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
    end
  end
endmodule : sync_fifo

// >>> logic/trigger_readout_and_lumi_logic.sv
// Fast command intake, trigger table, hit readout and luminosity path
`timescale 1ns/1ps
module trigger_readout_and_lumi_logic (
  input  wire logic                              core_clk,     // 50 MHz core clock
  input  wire logic                              rst,          // Async reset, high
  input  wire logic                              cmdClkIn,     // Link clock pin
  input  wire logic                              cmdDataIn,    // Serial command pin
  output logic                                   refClk,       // Link clock divided by 8
  output logic [readout_pkg::XING_W-1:0]         crossing,     // Crossing identifier
  output logic                                   trigPulse,    // Broadcast trigger
  output logic [readout_pkg::TAG_W-1:0]          trigTag,      // Broadcast tag
  output logic                                   trigDropped,  // Table full at accept
  output logic                                   eocFetch,     // Column-end fetch pulse
  output logic [readout_pkg::TAG_W-1:0]          eocTag,       // Tag to fetch
  input  wire logic [readout_pkg::HIT_W-1:0]     eocHit,       // Hit word from column ends
  input  wire logic                              eocHitValid,  // Hit word valid
  input  wire logic                              eocHitLast,   // Last hit of event
  output logic                                   eocReady,     // Can take hit word
  input  wire logic [1:0]                        rateSel,      // Hit link rate
  output logic [3:0]                             hitSer,       // Hit link lanes
  output logic                                   hitSerValid,  // Lanes carry data
  input  wire logic [readout_pkg::CHANNELS-1:0]  discHit,      // Discriminator pins
  input  wire logic                              lumiEnable,   // Luminosity enable
  input  wire logic [2:0]                        wideStart,    // Wide start, in steps
  input  wire logic [2:0]                        wideLen,      // Wide length, in steps
  output logic [readout_pkg::COLS-1:0]           narrowWin,    // Narrow window per column
  output logic [readout_pkg::COLS-1:0]           wideWin,      // Wide window per column
  output logic [readout_pkg::FRAME_W-1:0]        lumiFrame,    // Coded luminosity frame
  output logic                                   lumiValid,    // Frame strobe
  output logic [readout_pkg::LUMI_STEP-1:0]      lumiSer,      // Luminosity serial pair
  input  wire logic [readout_pkg::CFG_AW-1:0]    wb_adr_i,     // Wishbone address
  input  wire logic [7:0]                        wb_dat_i,     // Wishbone write data
  input  wire logic                              wb_we_i,      // Wishbone write
  input  wire logic                              wb_stb_i,     // Wishbone strobe
  input  wire logic                              wb_cyc_i,     // Wishbone cycle
  output logic [7:0]                             wb_dat_o,     // Wishbone read data
  output logic                                   wb_ack_o,     // Wishbone ack
  input  wire logic [readout_pkg::CFG_AW-1:0]    cfgRdAddr,    // Readback address
  output logic [7:0]                             cfgRdData,    // Readback data
  input  wire logic                              cfgUpsetClr,  // Clear upset flag
  output logic                                   cfgUpset      // Upset seen, sticky
);
  import readout_pkg::*;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Command pin synchronisers
  logic [2:0] clkSync;
  logic [2:0] datSync;
  logic       clkLvl;
  logic       datLvl;
  logic       bitStrobe;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clkSync <= '0;
      datSync <= '0;
      clkLvl  <= 1'b0;
      datLvl  <= 1'b0;
    end else begin
      clkSync <= {clkSync[1:0], cmdClkIn};
      datSync <= {datSync[1:0], cmdDataIn};
      if (clkSync[2] == clkSync[1]) clkLvl <= clkSync[2];
      if (datSync[2] == datSync[1]) datLvl <= datSync[2];
    end
  end
  assign bitStrobe = (clkSync[2] == clkSync[1]) && clkSync[2] && !clkLvl;  // [RULE2]

  // ==========================================================
  // Command deserialiser and divide-by-eight
  logic [2:0]       bitCnt;
  logic [CMD_W-1:0] cmdShift;
  logic [CMD_W-1:0] cmdWord;
  logic             xingStrobe;
  assign cmdWord    = {cmdShift[CMD_W-2:0], datLvl};
  assign xingStrobe = bitStrobe && (bitCnt == 3'(DIVIDE - 1));  // [RULE1]
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bitCnt   <= '0;
      cmdShift <= '0;
      refClk   <= 1'b0;
    end else if (bitStrobe) begin
      bitCnt   <= bitCnt + 1'b1;
      cmdShift <= cmdWord;
      if (bitCnt[1:0] == 2'h3) refClk <= !refClk;  // [RULE3]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      crossing <= '0;
    end else if (xingStrobe) begin
      crossing <= (cmdWord == CMD_XING_CLR) ? '0 : crossing + 1'b1;  // [RULE4]
    end
  end

  // ==========================================================
  // Trigger intake task
  logic                    accept;
  logic                    tabInReady;
  logic [XING_W+TAG_W-1:0] tabHead;
  logic                    tabValid;
  logic                    tabPop;
  logic [TAG_W-1:0]        tagNext;
  assign accept = xingStrobe && (cmdWord == CMD_ACCEPT);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trigPulse   <= 1'b0;
      trigTag     <= '0;
      tagNext     <= '0;
      trigDropped <= 1'b0;
    end else begin
      trigPulse   <= accept;  // [RULE6] [RULE7]
      trigDropped <= accept && !tabInReady;
      if (accept) begin
        trigTag <= tagNext;  // [RULE8]
        tagNext <= tagNext + 1'b1;
      end
    end
  end

  sync_fifo #(
    .WIDTH (XING_W + TAG_W),
    .DEPTH (TABLE_DEPTH)
  ) u_trigger_table (
    .core_clk (core_clk),
    .rst      (rst),
    .inData   ({crossing, tagNext}),  // [RULE9]
    .inValid  (accept),
    .inReady  (tabInReady),
    .outData  (tabHead),
    .outValid (tabValid),
    .outReady (tabPop)
  );

  // ==========================================================
  // Readout task
  typedef enum logic [3:0] {
    S_IDLE    = 4'b0001,
    S_FETCH   = 4'b0010,
    S_HEAD    = 4'b0100,
    S_COLLECT = 4'b1000
  } read_state_t;
  read_state_t             state;
  logic [XING_W+TAG_W-1:0] entry;
  logic [HIT_W-1:0]        holdHit;
  logic                    holdValid;
  logic [WORD_W-1:0]       serShift;
  logic [4:0]              serLeft;
  logic [4:0]              step;
  logic                    serFree;
  logic                    loadHead;
  logic                    loadHit;
  logic                    hitTake;

  assign tabPop   = (state == S_IDLE) && tabValid;  // [RULE5] [RULE10]
  assign serFree  = serLeft == '0;
  assign loadHead = (state == S_HEAD) && serFree;
  assign loadHit  = holdValid && serFree && (state == S_COLLECT);
  assign hitTake  = eocHitValid && eocReady;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state    <= S_IDLE;
      entry    <= '0;
      eocFetch <= 1'b0;
      eocTag   <= '0;
    end else begin
      eocFetch <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (tabValid) begin
            entry <= tabHead;
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          eocFetch <= 1'b1;  // [RULE10]
          eocTag   <= entry[TAG_W-1:0];
          state    <= S_HEAD;
        end
        S_HEAD: begin
          if (serFree) state <= S_COLLECT;
        end
        S_COLLECT: begin
          if (hitTake && eocHitLast) state <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      holdHit   <= '0;
      holdValid <= 1'b0;
      eocReady  <= 1'b0;
    end else begin
      if (hitTake) begin
        holdHit   <= eocHit;
        holdValid <= 1'b1;
      end else if (loadHit) begin
        holdValid <= 1'b0;
      end
      eocReady <= (state == S_COLLECT) && !(hitTake && eocHitLast) && !hitTake && !holdValid;
    end
  end

  always_comb begin
    unique case (rateSel)
      RATE_640:  step = 5'd2;
      RATE_1280: step = 5'd4;
      default:   step = 5'd1;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      serShift    <= '0;
      serLeft     <= '0;
      hitSer      <= '0;
      hitSerValid <= 1'b0;
    end else begin
      hitSerValid <= !serFree;
      if (loadHead) begin
        serShift <= {MARK_HEAD, cfgUpset, entry[TAG_W-1:0], entry[XING_W+TAG_W-1:TAG_W],
                     4'h0};  // [RULE11] [RULE23]
        serLeft  <= 5'(WORD_W);
      end else if (loadHit) begin
        serShift <= {MARK_HIT, entry[TAG_W-1:0], holdHit};  // [RULE11]
        serLeft  <= 5'(WORD_W);
      end else if (!serFree) begin
        unique case (step)
          5'd2:    hitSer <= {2'h0, serShift[WORD_W-1 -: 2]};  // [RULE12]
          5'd4:    hitSer <= serShift[WORD_W-1 -: 4];
          default: hitSer <= {3'h0, serShift[WORD_W-1]};
        endcase
        serShift <= serShift << step;
        serLeft  <= serLeft - step;
      end
    end
  end

  // ==========================================================
  // Per-channel configuration over Wishbone
  logic [8:0]          cfgMem [CFG_WORDS];
  logic [CHANNELS-1:0] chanEnable;
  logic                wbReq;
  logic                wbMapped;
  logic [8:0]          rdWord;
  assign wbReq    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbMapped = wb_adr_i <= CFG_LAST;
  assign rdWord   = cfgMem[cfgRdAddr];

  always_ff @(posedge core_clk) begin
    if (wbReq && wbMapped && wb_we_i) cfgMem[wb_adr_i] <= {^wb_dat_i, wb_dat_i};  // [RULE22]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= '0;
      chanEnable <= '1;
      cfgRdData  <= '0;
      cfgUpset   <= 1'b0;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= (wbReq && wbMapped) ? cfgMem[wb_adr_i][7:0] : '0;
      if (wbReq && wbMapped && wb_we_i && wb_adr_i[1:0] == 2'h0) begin
        chanEnable[wb_adr_i[CFG_AW-1:2]] <= wb_dat_i[CFG_EN_BIT];
      end
      cfgRdData <= rdWord[7:0];  // [RULE23]
      if ((cfgRdAddr <= CFG_LAST) && (^rdWord[7:0] != rdWord[8])) cfgUpset <= 1'b1;
      else if (cfgUpsetClr) cfgUpset <= 1'b0;
    end
  end

  // ==========================================================
  // Window generators and channel flags
  logic [PHASE_W-1:0]  phase [COLS];
  logic [COLS-1:0]     nWin;
  logic [COLS-1:0]     wWin;
  logic [CHANNELS-1:0] nFlag;
  logic [CHANNELS-1:0] wFlag;
  logic [3:0]          colN [COLS];
  logic [3:0]          colW [COLS];

  for (genvar c = 0; c < COLS; c++) begin : g_col
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        phase[c]     <= '0;
        narrowWin[c] <= 1'b0;
        wideWin[c]   <= 1'b0;
      end else begin
        phase[c]     <= (xingStrobe || !lumiEnable) ? '0 : phase[c] + 1'b1;  // [RULE24]
        narrowWin[c] <= nWin[c];  // [RULE14]
        wideWin[c]   <= wWin[c];
      end
    end
    assign nWin[c] = lumiEnable && (phase[c][3:1] == NARROW_FIRST[3:1]);  // [RULE13]
    assign wWin[c] = lumiEnable && ({1'b0, phase[c][3:1]} >= {1'b0, wideStart})
                     && ({1'b0, phase[c][3:1]} < ({1'b0, wideStart} + {1'b0, wideLen}));
    always_comb begin
      colN[c] = '0;
      colW[c] = '0;
      for (int r = 0; r < ROWS; r++) begin
        colN[c] = colN[c] + 4'(nFlag[c*ROWS+r]);  // [RULE16]
        colW[c] = colW[c] + 4'(wFlag[c*ROWS+r]);
      end
    end
  end

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    logic [2:0] hs;
    logic       hitLvl;
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        hs        <= '0;
        hitLvl    <= 1'b0;
        nFlag[ch] <= 1'b0;
        wFlag[ch] <= 1'b0;
      end else begin
        hs <= {hs[1:0], discHit[ch]};
        if (hs[2] == hs[1]) hitLvl <= hs[2];
        if (xingStrobe || !lumiEnable) begin
          nFlag[ch] <= 1'b0;
          wFlag[ch] <= 1'b0;
        end else if (hitLvl && chanEnable[ch]) begin
          if (narrowWin[ch/ROWS]) nFlag[ch] <= 1'b1;  // [RULE15]
          if (wideWin[ch/ROWS]) wFlag[ch] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Luminosity sums, word and coding
  logic [SUM_W-1:0]   nTot;
  logic [SUM_W-1:0]   wTot;
  logic [SUM_W-1:0]   diff;
  logic [LUMI_W-1:0]  lumiWord;
  logic [FRAME_W-1:0] lumiShift;

  function automatic logic [7:0] code6b8b(input logic [5:0] d);
    code6b8b = {d[5:3], ~d[5], d[2:0], ~d[2]};
  endfunction : code6b8b

  always_comb begin
    nTot = '0;
    wTot = '0;
    for (int c = 0; c < COLS; c++) begin
      nTot = nTot + SUM_W'(colN[c]);  // [RULE17]
      wTot = wTot + SUM_W'(colW[c]);
    end
    diff     = (wTot > nTot) ? wTot - nTot : '0;  // [RULE18]
    lumiWord = {(nTot > 8'h7F) ? 7'h7F : nTot[NARROW_OUT-1:0],
                (diff > 8'h1F) ? 5'h1F : diff[DIFF_OUT-1:0]};  // [RULE19]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lumiFrame <= '0;
      lumiValid <= 1'b0;
      lumiShift <= '0;
      lumiSer   <= '0;
    end else begin
      lumiValid <= xingStrobe && lumiEnable;  // [RULE21]
      if (!lumiEnable) begin
        lumiShift <= '0;
        lumiSer   <= '0;
      end else if (xingStrobe) begin
        lumiFrame <= {code6b8b(lumiWord[11:6]), code6b8b(lumiWord[5:0])};  // [RULE20]
        lumiShift <= {code6b8b(lumiWord[11:6]), code6b8b(lumiWord[5:0])};
      end else if (bitStrobe) begin
        lumiSer   <= lumiShift[FRAME_W-1 -: LUMI_STEP];
        lumiShift <= lumiShift << LUMI_STEP;
      end
    end
  end

  // ==========================================================
  // Checks
  sequence accept_seen;
    accept ##1 trigPulse;
  endsequence
  a_trigger_tag: assert property (accept_seen |-> trigTag == $past(tagNext))  // [RULE6]
    else $error("trigger tag not assigned on accept");
  a_crossing_step: assert property (xingStrobe && cmdWord != CMD_XING_CLR
    |=> crossing == $past(crossing) + 1'b1)  // [RULE4]
    else $error("crossing counter did not advance");
  a_divide_eight: assert property (xingStrobe |-> bitCnt == 3'h7)  // [RULE3]
    else $error("crossing strobe off the eighth bit");
  a_table_store: assert property (accept && tabInReady |=> tabValid || state != S_IDLE)  // [RULE9]
    else $error("accepted trigger missing from table");
  sequence entry_found;
    state == S_IDLE && tabValid;
  endsequence
  a_fetch_entry: assert property (entry_found |-> ##2 eocFetch && eocTag == $past(tabHead[4:0], 2))  // [RULE10]
    else $error("column-end fetch missing");
  a_head_frame: assert property (loadHead |=> serShift[WORD_W-1 -: 2] == MARK_HEAD
    && serLeft == 5'd24)  // [RULE11]
    else $error("header frame not loaded");
  a_narrow_width: assert property ($rose(nWin[0]) && !xingStrobe |=> nWin[0] ##1 !nWin[0])  // [RULE13]
    else $error("narrow window not two ticks");
  a_lumi_idle: assert property (!lumiEnable |=> !lumiValid && lumiShift == '0)  // [RULE21]
    else $error("luminosity active while disabled");
  a_lumi_frame: assert property (lumiValid |-> lumiFrame[15:8] == code6b8b($past(lumiWord[11:6])))  // [RULE20]
    else $error("luminosity frame coding wrong");
  a_wb_ack: assert property (wbReq |=> wb_ack_o ##1 !wb_ack_o)  // [RULE22]
    else $error("wishbone ack not single cycle");
endmodule : trigger_readout_and_lumi_logic

// >>> tb/link_partner.sv
// Link partner model: free-running link clock and serial fast commands
`timescale 1ns/1ps
module link_partner (
  input  wire logic core_clk,  // Core clock
  input  wire logic rst,       // Reset
  output logic      linkClk,   // Link clock pin
  output logic      linkData   // Command bit pin
);
  logic [7:0] q[$];
  logic [7:0] sh;
  logic [7:0] nx;
  int         left;
  int         ph;
  task automatic push(input logic [7:0] cmd);
    q.push_back(cmd);
  endtask : push
  // ==========================================================
  // Clock never stops; a new bit follows each falling link edge
  always @(negedge core_clk or posedge rst) begin
    if (rst) begin
      linkClk <= 1'b0;
      linkData <= 1'b0;
      sh <= 8'h00;
      left <= 7;
      ph <= 0;
    end else begin
      ph <= (ph + 1) % 4;
      if (ph == 3) linkClk <= ~linkClk;
      if (ph == 3 && linkClk && left == 0) begin
        nx = (q.size() > 0) ? q.pop_front() : 8'h00;
        linkData <= nx[7];
        sh <= {nx[6:0], 1'b0};
        left <= 7;
      end else if (ph == 3 && linkClk) begin
        linkData <= sh[7];
        sh <= {sh[6:0], 1'b0};
        left <= left - 1;
      end
    end
  end
endmodule : link_partner

// >>> tb/test_trigger_readout_and_lumi_logic.sv
// Self-checking bench for the trigger readout and luminosity logic
`timescale 1ns/1ps
module test_trigger_readout_and_lumi_logic;
  import readout_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic linkClk, linkData, refClk, trigPulse, eocFetch, eocReady, hitSerValid, lumiValid;
  logic wbAck, cfgUpset, hitValid, hitLast, lumiEnable, wbWe, wbCyc, upsetClr;
  logic [XING_W-1:0] crossing;
  logic [TAG_W-1:0] trigTag, eocTag;
  logic [HIT_W-1:0] eocHit = '0;
  logic [1:0] rateSel = RATE_320;
  logic [3:0] hitSer;
  logic [CHANNELS-1:0] discHit = '0;
  logic [COLS-1:0] narrowWin;
  logic [FRAME_W-1:0] lumiFrame;
  logic [CFG_AW-1:0] wbAdr = '0;
  logic [CFG_AW-1:0] cfgRdAddr = 10'h005;
  logic [7:0] wbDatW, wbDatR, cfgRdData, rd;
  int failures = 0;
  int checked = 0;
  always #10 core_clk = ~core_clk;
  link_partner partner (.core_clk(core_clk), .rst(rst), .linkClk(linkClk), .linkData(linkData));
  trigger_readout_and_lumi_logic dut (.core_clk(core_clk), .rst(rst), .cmdClkIn(linkClk),
    .cmdDataIn(linkData), .refClk(refClk), .crossing(crossing), .trigPulse(trigPulse),
    .trigTag(trigTag), .trigDropped(), .eocFetch(eocFetch), .eocTag(eocTag), .eocHit(eocHit),
    .eocHitValid(hitValid), .eocHitLast(hitLast), .eocReady(eocReady), .rateSel(rateSel),
    .hitSer(hitSer), .hitSerValid(hitSerValid), .discHit(discHit), .lumiEnable(lumiEnable),
    .wideStart(3'h1), .wideLen(3'h2), .narrowWin(narrowWin), .wideWin(), .lumiFrame(lumiFrame),
    .lumiValid(lumiValid), .lumiSer(), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_we_i(wbWe),
    .wb_stb_i(wbCyc), .wb_cyc_i(wbCyc), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .cfgRdAddr(cfgRdAddr), .cfgRdData(cfgRdData), .cfgUpsetClr(upsetClr), .cfgUpset(cfgUpset));
  function automatic bit same(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    return got === exp;
  endfunction : same
  task automatic fail(input logic [15:0] got, input logic [15:0] exp);
    failures++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
  endtask : fail
  task automatic tally_and_finish();
    $display("Counts: checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic waitSig(input int s);
    for (int n = 0; n < 400; n++) begin
      @(negedge core_clk);
      if (s == 0 ? trigPulse : s == 1 ? eocFetch : s == 2 ? hitSerValid : lumiValid) return;
    end
    fail(16'h0, 16'h1);
    tally_and_finish();
  endtask : waitSig
  task automatic sendHit(input logic [HIT_W-1:0] hit);
    @(negedge core_clk);
    eocHit = hit;
    hitLast = 1'b1;
    hitValid = 1'b1;
    for (int n = 0; n < 400 && eocReady !== 1'b1; n++) @(negedge core_clk);
    if (eocReady !== 1'b1) begin
      fail(16'(eocReady), 16'h1);
      tally_and_finish();
    end
    @(negedge core_clk);
    hitValid = 1'b0;
  endtask : sendHit
  task automatic wb(input logic we, input logic [CFG_AW-1:0] adr, input logic [7:0] dat);
    @(negedge core_clk);
    {wbWe, wbAdr, wbDatW, wbCyc} = {we, adr, dat, 1'b1};
    for (int n = 0; n < 20 && wbAck !== 1'b1; n++) @(negedge core_clk);
    rd = wbDatR;
    wbCyc = 1'b0;
    if (wbAck !== 1'b1) begin
      fail(16'(wbAck), 16'h1);
      tally_and_finish();
    end
  endtask : wb
  task automatic testConfig();
    wb(1'b1, 10'h005, 8'hA5);
    wb(1'b0, 10'h005, 8'h00);
    if (!same(rd, 8'hA5)) fail(rd, 8'hA5);
    wb(1'b0, 10'h3FF, 8'h00);
    if (!same(rd, 8'h00)) fail(rd, 8'h00);
    upsetClr = 1'b1;
    repeat (2) @(negedge core_clk);
    upsetClr = 1'b0;
    if (!same(cfgRdData, 8'hA5)) fail(cfgRdData, 8'hA5);
    if (!same(cfgUpset, 1'b0)) fail(cfgUpset, 1'b0);
    $display("done config");
  endtask : testConfig
  task automatic testCrossing();
    logic [XING_W-1:0] c0;
    logic r;
    int toggles;
    c0 = crossing;
    for (int n = 0; n < 100 && crossing === c0; n++) @(negedge core_clk);
    c0 = crossing;
    r = refClk;
    toggles = 0;
    repeat (256) begin
      @(negedge core_clk);
      if (refClk !== r) toggles++;
      r = refClk;
    end
    if (!same(crossing, c0 + 12'h004)) fail(crossing, c0 + 12'h004);
    if (!same(16'(toggles), 16'h8)) fail(16'(toggles), 16'h8);
    $display("done crossing");
  endtask : testCrossing
  task automatic testTrigger();
    logic [3:0] mask;
    logic [3:0] exp;
    for (int r = 0; r < 3; r++) begin
      partner.push(CMD_ACCEPT);
      waitSig(0);
      if (!same(trigTag, 5'(r))) fail(trigTag, 5'(r));
      rateSel = 2'(r);
      waitSig(1);
      if (!same(eocTag, 5'(r))) fail(eocTag, 5'(r));
      waitSig(2);
      mask = (r == 0) ? 4'h1 : (r == 1) ? 4'h3 : 4'hC;
      exp = (r == 0) ? 4'h1 : (r == 1) ? 4'h2 : 4'h8;
      if (!same(hitSer & mask, exp)) fail(hitSer & mask, exp);
      sendHit(17'h1A5A5 + 17'(r));
    end
    partner.push(CMD_ACCEPT);
    partner.push(CMD_ACCEPT);
    waitSig(1);
    if (!same(eocTag, 5'h03)) fail(eocTag, 5'h03);
    sendHit(17'h00001);
    waitSig(1);
    if (!same(eocTag, 5'h04)) fail(eocTag, 5'h04);
    sendHit(17'h00002);
    $display("done trigger");
  endtask : testTrigger
  task automatic testLumi();
    int seen;
    seen = 0;
    repeat (200) begin
      @(negedge core_clk);
      if (lumiValid === 1'b1) seen++;
    end
    if (!same(16'(seen), 16'h0)) fail(16'(seen), 16'h0);
    lumiEnable = 1'b1;
    waitSig(3);
    waitSig(3);
    if (!same(lumiFrame, 16'h1111)) fail(lumiFrame, 16'h1111);
    repeat (64) begin
      @(negedge core_clk);
      if (narrowWin[0] === 1'b1) seen++;
    end
    if (!same(16'(seen > 0), 16'h1)) fail(16'(seen > 0), 16'h1);
    $display("done lumi");
  endtask : testLumi
  initial begin
    {hitValid, hitLast, lumiEnable, wbWe, wbCyc, upsetClr, wbDatW} = '0;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    if (!same(crossing, 12'h000)) fail(crossing, 12'h000);
    testConfig();
    testCrossing();
    testTrigger();
    testLumi();
    tally_and_finish();
  end
endmodule : test_trigger_readout_and_lumi_logic
